/* tdpbr_pkg.sv */
// Shared constants and types for the dual-port block memory.
package tdpbr_pkg;

   // ------------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------------
   localparam int DATA_BITS   = 16384;
   localparam int PARITY_BITS = 2048;
   localparam int MAX_WIDTH   = 36;
   localparam int BYTE_GROUP  = 9;
   localparam int BYTE_DATA   = 8;

   // ------------------------------------------------------------------
   // Read-during-write output modes
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      TDPBR_WRITE_FIRST = 2'h0,
      TDPBR_READ_FIRST  = 2'h1,
      TDPBR_NO_CHANGE   = 2'h2
   } tdpbr_mode_t;

   // ------------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------------
   localparam int BUS_AW = 4;
   localparam int BUS_DW = 32;

   typedef struct packed {
      logic [BUS_AW-1:0] address;
      logic              read;
      logic              write;
      logic [BUS_DW-1:0] writedata;
      logic [3:0]        byteenable;
   } tdpbr_avs_req_t;

   localparam logic [BUS_AW-1:0] MODE_OFFSET   = 4'h0;
   localparam logic [BUS_AW-1:0] STATUS_OFFSET = 4'h4;

   localparam int MODE_A_LSB  = 0;
   localparam int MODE_B_LSB  = 2;
   localparam int STAT_WW_BIT = 0;
   localparam int STAT_RD_BIT = 1;

   localparam logic [1:0]        STATUS_RESET  = 2'h0;
   localparam logic              WAIT_RESET    = 1'h1;
   localparam logic [BUS_DW-1:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

/* tdpbr_top.sv */
// Dual-port synchronous block memory with a small control and status register slave.
`timescale 1ns/1ps

module tdpbr_top #(
   parameter int                           WIDTH_A  = 36,
   parameter int                           WIDTH_B  = 36,
   parameter tdpbr_pkg::tdpbr_mode_t       MODE_A   = tdpbr_pkg::TDPBR_WRITE_FIRST,
   parameter tdpbr_pkg::tdpbr_mode_t       MODE_B   = tdpbr_pkg::TDPBR_WRITE_FIRST,
   parameter logic [35:0]                  PRESET_A = 36'h0_0000_0000,
   parameter logic [35:0]                  PRESET_B = 36'h0_0000_0000,
   localparam int DW_A  = (WIDTH_A >= 9) ? (WIDTH_A / 9) * 8 : WIDTH_A,
   localparam int DW_B  = (WIDTH_B >= 9) ? (WIDTH_B / 9) * 8 : WIDTH_B,
   localparam int PW_A  = WIDTH_A / 9,
   localparam int PW_B  = WIDTH_B / 9,
   localparam int PX_A  = (PW_A > 0) ? PW_A : 1,
   localparam int PX_B  = (PW_B > 0) ? PW_B : 1,
   localparam int AW_A  = $clog2(16384 / DW_A),
   localparam int AW_B  = $clog2(16384 / DW_B)
) (
   input  wire logic                      clk_sys,
   input  wire logic                      srst,
   input  wire logic                      en_a,
   input  wire logic                      we_a,
   input  wire logic                      output_sync_preset_a,
   input  wire logic [AW_A-1:0]           addr_a,
   input  wire logic [DW_A-1:0]           write_data_bus_a,
   input  wire logic [PX_A-1:0]           write_parity_bus_a,
   output logic      [DW_A-1:0]           read_data_bus_a,
   output logic      [PX_A-1:0]           read_parity_bus_a,
   input  wire logic                      en_b,
   input  wire logic                      we_b,
   input  wire logic                      output_sync_preset_b,
   input  wire logic [AW_B-1:0]           addr_b,
   input  wire logic [DW_B-1:0]           write_data_bus_b,
   input  wire logic [PX_B-1:0]           write_parity_bus_b,
   output logic      [DW_B-1:0]           read_data_bus_b,
   output logic      [PX_B-1:0]           read_parity_bus_b,
   input  wire tdpbr_pkg::tdpbr_avs_req_t avs_req,
   output logic      [31:0]               avs_readdata,
   output logic                           avs_waitrequest
);

   // ------------------------------------------------------------------
   // Storage and port state
   // ------------------------------------------------------------------
   logic                   dmem_ff [0:tdpbr_pkg::DATA_BITS-1];
   logic                   pmem_ff [0:tdpbr_pkg::PARITY_BITS-1];
   logic [DW_A-1:0]        dout_a_ff;
   logic [PX_A-1:0]        pout_a_ff;
   logic [DW_B-1:0]        dout_b_ff;
   logic [PX_B-1:0]        pout_b_ff;
   tdpbr_pkg::tdpbr_mode_t mode_a_ff;
   tdpbr_pkg::tdpbr_mode_t mode_b_ff;
   logic [1:0]             status_ff;
   logic                   wait_ff;
   logic [31:0]            rdata_ff;

   logic                   wr_a;
   logic                   wr_b;
   logic [DW_A-1:0]        rdd_a;
   logic [PX_A-1:0]        rdp_a;
   logic [DW_B-1:0]        rdd_b;
   logic [PX_B-1:0]        rdp_b;
   logic [DW_A-1:0]        hitd_a;
   logic [PX_A-1:0]        hitp_a;
   logic [DW_B-1:0]        hitd_b;
   logic [PX_B-1:0]        hitp_b;
   logic [DW_B-1:0]        nxt_wd_b;
   logic [PX_B-1:0]        nxt_wp_b;
   logic                   ww_clash;
   logic                   rd_clash;

   // Write only when both enables are high.
   assign wr_a = en_a & we_a;
   assign wr_b = en_b & we_b;

   // ------------------------------------------------------------------
   // Array lookup and collision detection
   // ------------------------------------------------------------------
   // Shared linear array.
   // Bits are addressed linearly so that ports of any width share the same cells.
   always_comb
   begin
      int ka;
      int kb;
      int ba;
      int bb;
      ka       = 0;
      kb       = 0;
      ba       = int'(addr_a) * DW_A;
      bb       = int'(addr_b) * DW_B;
      ww_clash = 1'b0;
      rdp_a    = '0;
      hitp_a   = '0;
      rdp_b    = '0;
      hitp_b   = '0;
      nxt_wp_b = write_parity_bus_b;
      for (int i = 0; i < DW_A; i++)
      begin
         ka        = ba + i;
         rdd_a[i]  = dmem_ff[ka];
         hitd_a[i] = wr_b && (ka >= bb) && (ka < bb + DW_B);
      end
      for (int j = 0; j < DW_B; j++)
      begin
         kb          = bb + j;
         rdd_b[j]    = dmem_ff[kb];
         hitd_b[j]   = wr_a && (kb >= ba) && (kb < ba + DW_A);
         nxt_wd_b[j] = write_data_bus_b[j];
         // Disagreeing simultaneous writes leave the cell unknown.
         if (hitd_b[j] && wr_b && (write_data_bus_a[kb - ba] != write_data_bus_b[j]))
         begin
            nxt_wd_b[j] = 1'bx;
            ww_clash    = 1'b1;
         end
      end
      if (PW_A > 0)
      begin
         for (int i = 0; i < PW_A; i++)
         begin
            ka        = int'(addr_a) * PW_A + i;
            rdp_a[i]  = pmem_ff[ka];
            hitp_a[i] = wr_b && (PW_B > 0) && (ka >= int'(addr_b) * PW_B)
                        && (ka < int'(addr_b) * PW_B + PW_B);
         end
      end
      if (PW_B > 0)
      begin
         for (int j = 0; j < PW_B; j++)
         begin
            kb        = int'(addr_b) * PW_B + j;
            rdp_b[j]  = pmem_ff[kb];
            hitp_b[j] = wr_a && (PW_A > 0) && (kb >= int'(addr_a) * PW_A)
                        && (kb < int'(addr_a) * PW_A + PW_A);
            if (hitp_b[j] && wr_b
                && (write_parity_bus_a[kb - int'(addr_a) * PW_A] != write_parity_bus_b[j]))
            begin
               nxt_wp_b[j] = 1'bx;
               ww_clash    = 1'b1;
            end
         end
      end
      rd_clash = (en_a && !we_a && !output_sync_preset_a && mode_b_ff != tdpbr_pkg::TDPBR_READ_FIRST
                  && (|hitd_a || |hitp_a))
              || (en_b && !we_b && !output_sync_preset_b && mode_a_ff != tdpbr_pkg::TDPBR_READ_FIRST
                  && (|hitd_b || |hitp_b));
   end

   // ------------------------------------------------------------------
   // Array writes
   // ------------------------------------------------------------------
   // Writes always land.
   // Store each enabled port's data on the edge; port B carries the clash result.
   always_ff @(posedge clk_sys)
   begin
      if (wr_a)
      begin
         for (int i = 0; i < DW_A; i++)
            dmem_ff[int'(addr_a) * DW_A + i] <= write_data_bus_a[i];
         for (int i = 0; i < PW_A; i++)
            pmem_ff[int'(addr_a) * PW_A + i] <= write_parity_bus_a[i];
      end
      if (wr_b)
      begin
         for (int j = 0; j < DW_B; j++)
            dmem_ff[int'(addr_b) * DW_B + j] <= nxt_wd_b[j];
         for (int j = 0; j < PW_B; j++)
            pmem_ff[int'(addr_b) * PW_B + j] <= nxt_wp_b[j];
      end
   end

   // ------------------------------------------------------------------
   // Output latches, port A
   // ------------------------------------------------------------------
   // Registered, held outputs.
   // Mode applies only while write enable is high.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         dout_a_ff <= '0;
         pout_a_ff <= '0;
      end
      else if (en_a)
      begin
         if (output_sync_preset_a)
         begin
            dout_a_ff <= PRESET_A[DW_A-1:0];
            pout_a_ff <= (PW_A > 0) ? PRESET_A[DW_A +: PX_A] : '0;
         end
         else if (we_a)
         begin
            unique case (mode_a_ff)
               tdpbr_pkg::TDPBR_WRITE_FIRST:
               begin
                  dout_a_ff <= write_data_bus_a;
                  pout_a_ff <= (PW_A > 0) ? write_parity_bus_a : '0;
               end
               tdpbr_pkg::TDPBR_READ_FIRST:
               begin
                  dout_a_ff <= rdd_a;
                  pout_a_ff <= rdp_a;
               end
               default:
               begin
                  dout_a_ff <= dout_a_ff;
                  pout_a_ff <= pout_a_ff;
               end
            endcase
         end
         else
         begin
            // Bits written by the other port read unknown unless it reads first.
            for (int i = 0; i < DW_A; i++)
               dout_a_ff[i] <= (hitd_a[i] && mode_b_ff != tdpbr_pkg::TDPBR_READ_FIRST)
                               ? 1'bx : rdd_a[i];
            for (int i = 0; i < PX_A; i++)
               pout_a_ff[i] <= (hitp_a[i] && mode_b_ff != tdpbr_pkg::TDPBR_READ_FIRST)
                               ? 1'bx : rdp_a[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // Output latches, port B
   // ------------------------------------------------------------------
   // Independent vector port.
   // Mode applies only while write enable is high.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         dout_b_ff <= '0;
         pout_b_ff <= '0;
      end
      else if (en_b)
      begin
         if (output_sync_preset_b)
         begin
            dout_b_ff <= PRESET_B[DW_B-1:0];
            pout_b_ff <= (PW_B > 0) ? PRESET_B[DW_B +: PX_B] : '0;
         end
         else if (we_b)
         begin
            unique case (mode_b_ff)
               tdpbr_pkg::TDPBR_WRITE_FIRST:
               begin
                  dout_b_ff <= nxt_wd_b;
                  pout_b_ff <= (PW_B > 0) ? nxt_wp_b : '0;
               end
               tdpbr_pkg::TDPBR_READ_FIRST:
               begin
                  dout_b_ff <= rdd_b;
                  pout_b_ff <= rdp_b;
               end
               default:
               begin
                  dout_b_ff <= dout_b_ff;
                  pout_b_ff <= pout_b_ff;
               end
            endcase
         end
         else
         begin
            // Only overlapping bits are made unknown.
            for (int j = 0; j < DW_B; j++)
               dout_b_ff[j] <= (hitd_b[j] && mode_a_ff != tdpbr_pkg::TDPBR_READ_FIRST)
                               ? 1'bx : rdd_b[j];
            for (int j = 0; j < PX_B; j++)
               pout_b_ff[j] <= (hitp_b[j] && mode_a_ff != tdpbr_pkg::TDPBR_READ_FIRST)
                               ? 1'bx : rdp_b[j];
         end
      end
   end

   assign read_data_bus_a   = dout_a_ff;
   assign read_parity_bus_a = pout_a_ff;
   assign read_data_bus_b   = dout_b_ff;
   assign read_parity_bus_b = pout_b_ff;

   // ------------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------------
   // Every access takes one wait cycle, so the answer never depends on the array.
   logic bus_take;
   assign bus_take = (avs_req.read | avs_req.write) & ~wait_ff;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         wait_ff <= tdpbr_pkg::WAIT_RESET;
      else
         wait_ff <= ~((avs_req.read | avs_req.write) & wait_ff);
   end

   // Modes start from the static parameters; software may change them.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         mode_a_ff <= MODE_A;
         mode_b_ff <= MODE_B;
      end
      else if (bus_take && avs_req.write && avs_req.address == tdpbr_pkg::MODE_OFFSET
               && avs_req.byteenable[0])
      begin
         mode_a_ff <= tdpbr_pkg::tdpbr_mode_t'(avs_req.writedata[tdpbr_pkg::MODE_A_LSB +: 2]);
         mode_b_ff <= tdpbr_pkg::tdpbr_mode_t'(avs_req.writedata[tdpbr_pkg::MODE_B_LSB +: 2]);
      end
   end

   // Sticky collision flags; a new event wins over a clear.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         status_ff <= tdpbr_pkg::STATUS_RESET;
      else
      begin
         logic [1:0] clr;
         clr = '0;
         if (bus_take && avs_req.write && avs_req.address == tdpbr_pkg::STATUS_OFFSET
             && avs_req.byteenable[0])
            clr = avs_req.writedata[1:0];
         status_ff <= (status_ff & ~clr) | {rd_clash, ww_clash};
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         rdata_ff <= tdpbr_pkg::UNMAPPED_DATA;
      else if ((avs_req.read | avs_req.write) && wait_ff)
      begin
         unique case (avs_req.address)
            tdpbr_pkg::MODE_OFFSET:   rdata_ff <= {28'h0000000, mode_b_ff, mode_a_ff};
            tdpbr_pkg::STATUS_OFFSET: rdata_ff <= {30'h00000000, status_ff};
            default:                  rdata_ff <= tdpbr_pkg::UNMAPPED_DATA;
         endcase
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_hold_disabled: assert property (@(posedge clk_sys) disable iff (srst)
      !en_a |=> $stable(read_data_bus_a))
      else $error("Port A output moved while disabled.");

   a_preset_load: assert property (@(posedge clk_sys) disable iff (srst)
      en_a && output_sync_preset_a |=> read_data_bus_a == PRESET_A[DW_A-1:0])
      else $error("Port A preset value not loaded.");

   a_echo_write: assert property (@(posedge clk_sys) disable iff (srst)
      wr_a && !output_sync_preset_a && mode_a_ff == tdpbr_pkg::TDPBR_WRITE_FIRST
      |=> read_data_bus_a == $past(write_data_bus_a))
      else $error("Port A transparent write did not echo input.");

   a_old_first: assert property (@(posedge clk_sys) disable iff (srst)
      wr_a && !output_sync_preset_a && mode_a_ff == tdpbr_pkg::TDPBR_READ_FIRST
      |=> read_data_bus_a == $past(rdd_a))
      else $error("Port A did not show the old word.");

   a_nochange_hold: assert property (@(posedge clk_sys) disable iff (srst)
      wr_a && !output_sync_preset_a && mode_a_ff == tdpbr_pkg::TDPBR_NO_CHANGE
      |=> $stable(read_data_bus_a))
      else $error("Port A output changed in hold mode.");

   a_write_readback: assert property (@(posedge clk_sys) disable iff (srst)
      wr_a && !wr_b && !output_sync_preset_a ##1
      en_a && !we_a && !output_sync_preset_a && !wr_b && addr_a == $past(addr_a)
      |=> read_data_bus_a == $past(write_data_bus_a, 2))
      else $error("Port A read did not return the written data.");

   a_same_read: assert property (@(posedge clk_sys) disable iff (srst)
      WIDTH_A == WIDTH_B && en_a && en_b && !we_a && !we_b && !output_sync_preset_a
      && !output_sync_preset_b && int'(addr_a) == int'(addr_b)
      |=> int'(read_data_bus_a) == int'(read_data_bus_b))
      else $error("Simultaneous reads differ.");

   a_bus_answer: assert property (@(posedge clk_sys) disable iff (srst)
      (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("Register bus answer not after one wait cycle.");

   a_clash_flag: assert property (@(posedge clk_sys) disable iff (srst)
      ww_clash |=> status_ff[tdpbr_pkg::STAT_WW_BIT])
      else $error("Write clash not flagged.");

endmodule

/* tdpbr_user_port.sv */
// Model of the user logic that drives one memory port.
`timescale 1ns/1ps
module tdpbr_user_port #(
   parameter int AW = 9,
   parameter int DW = 32,
   localparam int PX = (DW >= 8) ? DW / 8 : 1
) (
   output logic          en,
   output logic          we,
   output logic          preset,
   output logic [AW-1:0] addr,
   output logic [DW-1:0] wdata,
   output logic [PX-1:0] wpar
);
   initial
   begin
      en = 1'b0;
      we = 1'b0;
      preset = 1'b0;
      addr = '0;
      wdata = '0;
      wpar = '0;
   end

   // caller schedules ports
   // An idle port flips address and data so a stale value never passes for a request.
   task automatic drive(input logic e, input logic w, input logic p, input logic [AW-1:0] a,
                        input logic [DW-1:0] d, input logic [PX-1:0] q);
      en     <= e;
      we     <= w;
      preset <= p;
      addr   <= e ? a : ~addr;
      wdata  <= e ? d : ~wdata;
      wpar   <= e ? q : ~wpar;
   endtask
endmodule

/* tdpbr_tb_top.sv */
// Self-checking testbench for the dual-port block memory.
`timescale 1ns/1ps
module tdpbr_tb_top;
   logic                      clk_sys, srst;
   logic                      en_a, we_a, output_sync_preset_a;
   logic                      en_b, we_b, output_sync_preset_b;
   logic [8:0]                addr_a;
   logic [31:0]               write_data_bus_a, read_data_bus_a;
   logic [3:0]                write_parity_bus_a, read_parity_bus_a;
   logic [10:0]               addr_b;
   logic [7:0]                write_data_bus_b, read_data_bus_b;
   logic [0:0]                write_parity_bus_b, read_parity_bus_b;
   tdpbr_pkg::tdpbr_avs_req_t avs_req;
   logic [31:0]               avs_readdata;
   logic                      avs_waitrequest;
   int                        n_mismatch, total_checks;
   wire logic [35:0]          out_a = {read_parity_bus_a, read_data_bus_a};
   wire logic [8:0]           out_b = {read_parity_bus_b, read_data_bus_b};

   tdpbr_top #(
      .WIDTH_B  (9),
      .PRESET_A (36'hA_5A5A_5A5A),
      .PRESET_B (36'h0_0000_01C3)
   ) DUT (
      .clk_sys, .srst, .en_a, .we_a, .output_sync_preset_a, .addr_a, .write_data_bus_a,
      .write_parity_bus_a, .read_data_bus_a, .read_parity_bus_a, .en_b, .we_b,
      .output_sync_preset_b, .addr_b, .write_data_bus_b, .write_parity_bus_b,
      .read_data_bus_b, .read_parity_bus_b, .avs_req, .avs_readdata, .avs_waitrequest
   );
   tdpbr_user_port u_port_a (
      .en(en_a), .we(we_a), .preset(output_sync_preset_a), .addr(addr_a),
      .wdata(write_data_bus_a), .wpar(write_parity_bus_a)
   );
   tdpbr_user_port #(.AW(11), .DW(8)) u_port_b (
      .en(en_b), .we(we_b), .preset(output_sync_preset_b), .addr(addr_b),
      .wdata(write_data_bus_b), .wpar(write_parity_bus_b)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Request is held until waitrequest is seen low at an edge, then released.
   task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_req <= '{address: a, read: ~wr, write: wr, writedata: d, byteenable: 4'hF};
      // Waitrequest is looked at mid-cycle, so the edge that follows is the taking edge.
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      @(posedge clk_sys);
      q = avs_readdata;
      if (n >= 50)
         n_mismatch++;
      avs_req <= '0;
   endtask

   task automatic set_modes(input logic [1:0] ma, input logic [1:0] mb);
      logic [31:0] q;
      avs(1'b1, 4'h0, {28'h0, mb, ma}, q);
   endtask

   task automatic sa(input logic e, w, p, input logic [8:0] a, input logic [35:0] v);
      @(posedge clk_sys);
      u_port_a.drive(e, w, p, a, v[31:0], v[35:32]);
   endtask

   task automatic wb(input logic e, w, p, input logic [10:0] a, input logic [8:0] v);
      u_port_b.drive(e, w, p, a, v[7:0], v[8]);
   endtask

   task automatic look;
      @(negedge clk_sys);
   endtask

   task automatic t_regs;
      logic [31:0] q;
      look;
      check("port a reset", out_a, 36'h0);
      check("port b reset", out_b, 9'h0);
      avs(1'b0, 4'h0, 32'h0, q);
      check("mode reset", q, 36'h0);
      avs(1'b0, 4'h4, 32'h0, q);
      check("status reset", q, 36'h0);
      avs(1'b1, 4'h8, 32'hFFFF_FFFF, q);
      avs(1'b0, 4'h8, 32'h0, q);
      check("unmapped read", q, 36'h0);
      avs(1'b0, 4'h0, 32'h0, q);
      check("mode untouched", q, 36'h0);
      set_modes(2'h2, 2'h1);
      avs(1'b0, 4'h0, 32'h0, q);
      check("mode readback", q, 36'h6);
      $display("register test done");
   endtask

   task automatic t_modes;
      logic [35:0] exp;
      for (int m = 0; m < 3; m++)
      begin
         set_modes(2'(m), 2'h0);
         sa(1, 1, 0, 9'h1, 36'h1_1111_1110 + m);
         sa(1, 1, 0, 9'h2, 36'h2_2222_2222);
         sa(1, 0, 0, 9'h1, 36'hF_DEAD_BEEF);
         sa(1, 1, 0, 9'h2, 36'h3_3333_3333);
         look;
         check("plain read", out_a, 36'h1_1111_1110 + m);
         sa(0, 1, 0, 9'h2, 36'hF_FFFF_FFFF);
         exp = (m == 0) ? 36'h3_3333_3333 : (m == 1) ? 36'h2_2222_2222 : 36'h1_1111_1110 + m;
         look;
         check("write output", out_a, exp);
         sa(1, 0, 0, 9'h2, 36'h0);
         wb(1, 0, 0, 11'h9, 9'h0);
         look;
         check("output held", out_a, exp);
         sa(0, 0, 0, 9'h0, 36'h0);
         wb(0, 0, 0, 11'h0, 9'h0);
         look;
         check("read back a", out_a, 36'h3_3333_3333);
         check("read back b", out_b, 9'h133);
      end
      $display("mode test done");
   endtask

   task automatic t_collide;
      logic [35:0] exp;
      set_modes(2'h1, 2'h0);
      sa(1, 0, 0, 9'h2, 36'h0);
      wb(1, 0, 0, 11'h8, 9'h0);
      sa(1, 1, 0, 9'h2, 36'h4_4444_4444);
      look;
      check("same read a", out_a, 36'h3_3333_3333);
      check("same read b", out_b, 9'h133);
      sa(0, 0, 0, 9'h0, 36'h0);
      wb(0, 0, 0, 11'h0, 9'h0);
      look;
      check("old data to reader", out_b, 9'h133);
      set_modes(2'h0, 2'h0);
      sa(1, 1, 0, 9'h2, 36'h5_5555_5555);
      wb(1, 0, 0, 11'h9, 9'h0);
      sa(1, 0, 0, 9'h2, 36'h0);
      wb(0, 0, 0, 11'h0, 9'h0);
      look;
      check("writer transparent", out_a, 36'h5_5555_5555);
      check("reader invalid", out_b, 9'hXXX);
      sa(1, 0, 0, 9'h2, 36'h0);
      wb(1, 1, 0, 11'h8, 9'h066);
      look;
      check("write took effect", out_a, 36'h5_5555_5555);
      sa(1, 0, 0, 9'h2, 36'h0);
      wb(0, 0, 0, 11'h0, 9'h0);
      exp = 36'h5_5555_5555;
      exp[7:0] = 'x;
      exp[32] = 1'bx;
      look;
      check("only shared bits invalid", out_a, exp);
      check("narrow writer output", out_b, 9'h066);
      sa(1, 1, 0, 9'h3, 36'hF_7777_7777);
      wb(1, 1, 0, 11'hC, 9'h088);
      look;
      check("later read new", out_a, 36'h4_5555_5566);
      sa(1, 1, 0, 9'h4, 36'h1_1234_5678);
      wb(1, 1, 0, 11'h10, 9'h178);
      sa(1, 0, 0, 9'h3, 36'h0);
      wb(0, 0, 0, 11'h0, 9'h0);
      sa(1, 0, 0, 9'h4, 36'h0);
      exp = 36'hF_7777_7700;
      exp[7:0] = 'x;
      exp[32] = 1'bx;
      look;
      check("clashing writes", out_a, exp);
      sa(0, 0, 0, 9'h0, 36'h0);
      look;
      check("agreeing writes", out_a, 36'h1_1234_5678);
      $display("collision test done");
   endtask

   task automatic t_preset;
      sa(1, 1, 1, 9'h6, 36'h9_9999_9999);
      wb(1, 0, 1, 11'h0, 9'h0);
      sa(1, 0, 0, 9'h6, 36'h0);
      wb(0, 0, 0, 11'h0, 9'h0);
      look;
      check("preset a", out_a, 36'hA_5A5A_5A5A);
      check("preset b", out_b, 9'h1C3);
      sa(0, 0, 1, 9'h6, 36'h0);
      look;
      check("array kept write", out_a, 36'h9_9999_9999);
      sa(0, 0, 0, 9'h0, 36'h0);
      look;
      check("preset needs enable", out_a, 36'h9_9999_9999);
      $display("preset test done");
   endtask

   initial
   begin
      srst = 1'b1;
      avs_req = '0;
      n_mismatch = 0;
      total_checks = 0;
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      t_regs;
      t_modes;
      t_collide;
      t_preset;
      test_done;
   end

   // The run needs under a hundred cycles; this limit of 5000 cycles leaves a wide margin.
   initial
   begin
      #100000;
      n_mismatch++;
      test_done;
   end
endmodule
